/* include/snapshot_pkg.sv */
// Constants for the fault snapshot record read-out block
package snapshot_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h60;
  localparam logic [7:0] CMD_EVENT_READ = 8'hD7;
  localparam logic [7:0] CMD_SELECTOR = 8'hD8;
  localparam int REC_BITS = 208;
  localparam logic [4:0] REC_BYTES = 5'h1A;
  localparam int DEPTH = 8;
  localparam logic [3:0] DEPTH_CNT = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  // Record field positions
  localparam int ID_LSB = 0;
  localparam int VIN_LSB = 16;
  localparam int VOUT_LSB = 32;
  localparam int IOUT_LSB = 48;
  localparam int TEMP_LSB = 64;
  localparam int DUTY_LSB = 80;
  localparam int AVG_OC_BIT = 158;
  localparam int SYNC_BIT = 159;
  localparam int ERR_STATE_LSB = 160;
  localparam int OLD_STATE_LSB = 164;
  localparam int TICKS_HI_LSB = 168;
  localparam int TICKS_LO_LSB = 176;
  typedef enum logic [3:0] {
    CTRL_IDLE = 4'b0000,
    CTRL_TON_WAIT = 4'b0001,
    CTRL_RAMP_UP = 4'b0010,
    CTRL_REGULATING = 4'b0011,
    CTRL_TOFF_WAIT = 4'b0100,
    CTRL_RAMP_DOWN = 4'b0101,
    CTRL_FAULT = 4'b0110
  } ctrl_state_type;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_RX = 3'b001,
    BUS_RACK = 3'b010,
    BUS_TX = 3'b011,
    BUS_TACK = 3'b100
  } bus_state_type;
endpackage

/* rtl/fault_snapshot_readout.sv */
// Fault snapshot store with management serial bus read-out
// What this block does
// - Selector command reports stored snapshot count and picks the record read.
// - Input voltage sits in record bits 31:16.
// - Output voltage sits in record bits 47:32.
// - Output current sits in record bits 63:48.
// - Duty cycle in percent sits in record bits 95:80.
// - Tick count low part on top, most significant byte below it.
// - Four-bit state from about 4 ms before the fault, fixed encoding.
// - Four-bit state at fault detection, same encoding.
// - Bit 159 sync fault, bit 158 averaged overcurrent fault, 1 = fault.
`timescale 1ns/10ps
module fault_snapshot_readout
  import snapshot_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Management bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Snapshot capture
  input wire logic cap_valid,
  input wire logic [15:0] cap_event_id,
  input wire logic [15:0] cap_vin,
  input wire logic [15:0] cap_vout,
  input wire logic [15:0] cap_iout,
  input wire logic [15:0] cap_temp,
  input wire logic [15:0] cap_duty,
  input wire ctrl_state_type cap_old_state,
  input wire ctrl_state_type cap_err_state,
  input wire logic cap_sync_fault,
  input wire logic cap_avg_oc_fault,
  input wire logic [7:0] cap_ticks_hi,
  input wire logic [31:0] cap_ticks_lo,
  // Status
  output logic [3:0] stored_count
);
  logic [REC_BITS-1:0] otp_mem [DEPTH];
  logic [REC_BITS-1:0] cap_record;
  logic scl_m_reg, scl_s_reg, scl_p_reg;
  logic sda_m_reg, sda_s_reg, sda_p_reg;
  bus_state_type state_reg, state_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic is_addr_reg, is_addr_next;
  logic have_cmd_reg, have_cmd_next;
  logic rd_reg, rd_next;
  logic ack_pend_reg, ack_pend_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [4:0] nbyte_reg, nbyte_next;
  logic [2:0] sel_reg, sel_next;
  logic [3:0] count_reg, count_next;
  logic oe_reg, oe_next;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] rx_byte, tx_byte;

  // Record assembly
  always_comb begin
    cap_record = '0;
    cap_record[ID_LSB +: 16] = cap_event_id;
    cap_record[VIN_LSB +: 16] = cap_vin;
    cap_record[VOUT_LSB +: 16] = cap_vout;
    cap_record[IOUT_LSB +: 16] = cap_iout;
    cap_record[TEMP_LSB +: 16] = cap_temp;
    cap_record[DUTY_LSB +: 16] = cap_duty;
    cap_record[AVG_OC_BIT] = cap_avg_oc_fault;
    cap_record[SYNC_BIT] = cap_sync_fault;
    cap_record[ERR_STATE_LSB +: 4] = cap_err_state;
    cap_record[OLD_STATE_LSB +: 4] = cap_old_state;
    cap_record[TICKS_HI_LSB +: 8] = cap_ticks_hi;
    cap_record[TICKS_LO_LSB +: 32] = cap_ticks_lo;
  end

  // Store: each slot is programmed once, until a reset clears the count and writes restart at slot 0
  always_ff @(posedge clock) begin
    if (cap_valid && count_reg < DEPTH_CNT) begin
      otp_mem[count_reg[2:0]] <= cap_record;
    end
  end

  // Pin synchronisers and edge detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_p_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_p_reg <= sda_s_reg;
    end
  end

  assign scl_rise = scl_s_reg & ~scl_p_reg;
  assign scl_fall = ~scl_s_reg & scl_p_reg;
  assign start_cond = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
  assign stop_cond = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;
  assign rx_byte = {shift_reg[6:0], sda_s_reg};

  // Byte to send for the current read position
  always_comb begin
    tx_byte = FILL_BYTE;
    if (cmd_reg == CMD_EVENT_READ) begin
      if (nbyte_reg == 5'h00) begin
        tx_byte = {3'h0, REC_BYTES};
      end else if (nbyte_reg <= REC_BYTES) begin
        tx_byte = otp_mem[sel_reg][(nbyte_reg - 5'h01) * 8 +: 8];
      end
    end else if (cmd_reg == CMD_SELECTOR && nbyte_reg == 5'h00) begin
      tx_byte = {4'h0, count_reg};
    end
  end

  // Bus protocol and register next values
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    is_addr_next = is_addr_reg;
    have_cmd_next = have_cmd_reg;
    rd_next = rd_reg;
    ack_pend_next = ack_pend_reg;
    cmd_next = cmd_reg;
    nbyte_next = nbyte_reg;
    sel_next = sel_reg;
    oe_next = oe_reg;
    count_next = count_reg;
    if (cap_valid && count_reg < DEPTH_CNT) begin
      count_next = count_reg + 4'h1;
    end
    if (start_cond) begin
      state_next = BUS_RX;
      bit_next = 3'h0;
      is_addr_next = 1'b1;
      ack_pend_next = 1'b0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      state_next = BUS_IDLE;
      have_cmd_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        BUS_IDLE: begin
          oe_next = 1'b0;
        end
        BUS_RX: begin
          if (scl_rise && !ack_pend_reg) begin
            shift_next = rx_byte;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              ack_pend_next = 1'b1;
              if (is_addr_reg) begin
                is_addr_next = 1'b0;
                rd_next = rx_byte[0];
                nbyte_next = 5'h00;
                if (rx_byte[7:1] != DEV_ADDR) begin
                  state_next = BUS_IDLE;
                  ack_pend_next = 1'b0;
                end
              end else if (!have_cmd_reg) begin
                have_cmd_next = 1'b1;
                cmd_next = rx_byte;
              end else if (cmd_reg == CMD_SELECTOR &&
                           rx_byte < {4'h0, count_reg}) begin
                sel_next = rx_byte[2:0];
              end
            end
          end else if (scl_fall && ack_pend_reg) begin
            ack_pend_next = 1'b0;
            oe_next = 1'b1;
            state_next = BUS_RACK;
          end
        end
        BUS_RACK: begin
          if (scl_fall) begin
            bit_next = 3'h0;
            if (rd_reg) begin
              shift_next = tx_byte;
              oe_next = ~tx_byte[7];
              state_next = BUS_TX;
            end else begin
              oe_next = 1'b0;
              state_next = BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              oe_next = 1'b0;
              state_next = BUS_TACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        BUS_TACK: begin
          if (scl_rise) begin
            if (sda_s_reg) begin
              state_next = BUS_IDLE;
            end else begin
              nbyte_next = (nbyte_reg == 5'h1F) ? nbyte_reg :
                           nbyte_reg + 5'h01;
              state_next = BUS_RACK;
            end
          end
        end
        default: begin
          state_next = BUS_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= BUS_IDLE;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      is_addr_reg <= 1'b0;
      have_cmd_reg <= 1'b0;
      rd_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      cmd_reg <= 8'h00;
      nbyte_reg <= 5'h00;
      sel_reg <= 3'h0;
      count_reg <= 4'h0;
      oe_reg <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      is_addr_reg <= is_addr_next;
      have_cmd_reg <= have_cmd_next;
      rd_reg <= rd_next;
      ack_pend_reg <= ack_pend_next;
      cmd_reg <= cmd_next;
      nbyte_reg <= nbyte_next;
      sel_reg <= sel_next;
      count_reg <= count_next;
      oe_reg <= oe_next;
      sda_out <= 1'b0;
    end
  end

  assign sda_oe = oe_reg;
  assign stored_count = count_reg;
endmodule

/* verif/snapshot_chk.sv */
// Port checker for the snapshot read-out block
`timescale 1ns/10ps
module snapshot_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Observed pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic cap_valid,
  input wire logic [3:0] stored_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_max; stored_count <= 4'h8; endproperty
  a_max: assert property (p_max) else $error("count above depth");
  property p_inc;
    cap_valid && stored_count < 4'h8 |=>
      stored_count == $past(stored_count) + 4'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("capture not counted");
  property p_full; stored_count == 4'h8 |=> stored_count == 4'h8; endproperty
  a_full: assert property (p_full) else $error("full store changed");
  property p_idle; !cap_valid |=> $stable(stored_count); endproperty
  a_idle: assert property (p_idle) else $error("count moved");
  property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
  a_rise: assert property (p_rise) else $error("pull with clock high");
  property p_fall; $fell(sda_oe) |-> !scl_in; endproperty
  a_fall: assert property (p_fall) else $error("release clock high");
  property p_hold; scl_in [*5] |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  c_first: cover property (cap_valid && stored_count == 4'h0);
  c_full: cover property (cap_valid && stored_count == 4'h8);
  c_ack: cover property ($rose(sda_oe));
endmodule
bind fault_snapshot_readout snapshot_chk chk (.clock, .rstn, .scl_in,
  .sda_out, .sda_oe, .cap_valid, .stored_count);

/* verif/bus_host.sv */
// Management bus host model
`timescale 1ns/10ps
module bus_host (
  // Clock
  input wire logic clock,
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves only mid low phase
  task automatic put_bit(input logic b);
    scl <= 1'b0;
    repeat (4) @(posedge clock);
    sda_pull <= !b;
    repeat (4) @(posedge clock);
    scl <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // One start, zero stop
  task automatic cond(input logic s);
    put_bit(s);
    sda_pull <= s;
    repeat (8) @(posedge clock);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    put_bit(1'b1);
    ack = sda;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1);
      d[i] = sda;
    end
    put_bit(last);
  endtask
endmodule

/* verif/testbench.sv */
// Testbench for the fault snapshot read-out block
`timescale 1ns/10ps
module testbench;
  import snapshot_pkg::*;
  logic clock, rstn, cap_valid, sda_out, sda_oe, scl, sda_pull, a1, a2;
  logic [207:0] rec [8];
  logic [15:0] cap_event_id, cap_vin, cap_vout;
  logic [15:0] cap_iout, cap_temp, cap_duty;
  logic cap_sync_fault, cap_avg_oc_fault;
  logic [7:0] cap_ticks_hi;
  logic [31:0] cap_ticks_lo;
  ctrl_state_type cap_old_state, cap_err_state;
  logic [7:0] rd;
  logic [3:0] stored_count;
  int miscompares = 0;
  int total_checks = 0;
  wire sda = !(sda_oe || sda_pull);
  fault_snapshot_readout dut (.clock(clock), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cap_valid(cap_valid),
    .cap_event_id(cap_event_id), .cap_vin(cap_vin), .cap_vout(cap_vout),
    .cap_iout(cap_iout), .cap_temp(cap_temp), .cap_duty(cap_duty),
    .cap_old_state(cap_old_state), .cap_err_state(cap_err_state),
    .cap_sync_fault(cap_sync_fault), .cap_avg_oc_fault(cap_avg_oc_fault),
    .cap_ticks_hi(cap_ticks_hi), .cap_ticks_lo(cap_ticks_lo),
    .stored_count(stored_count));
  bus_host host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Spread one record over the capture inputs
  task automatic drive_rec(input logic [207:0] r);
    cap_event_id <= r[15:0];
    cap_vin <= r[31:16];
    cap_vout <= r[47:32];
    cap_iout <= r[63:48];
    cap_temp <= r[79:64];
    cap_duty <= r[95:80];
    cap_avg_oc_fault <= r[158];
    cap_sync_fault <= r[159];
    cap_err_state <= ctrl_state_type'(r[163:160]);
    cap_old_state <= ctrl_state_type'(r[167:164]);
    cap_ticks_hi <= r[175:168];
    cap_ticks_lo <= r[207:176];
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic open_cmd(input logic [7:0] cmd);
    host.cond(1'b1);
    host.send({DEV_ADDR, 1'b0}, a1);
    host.send(cmd, a2);
    check({6'h00, a1, a2}, 8'h00);
  endtask
  task automatic read_sel(input logic [3:0] n);
    open_cmd(CMD_SELECTOR);
    host.cond(1'b1);
    host.send({DEV_ADDR, 1'b1}, a1);
    host.recv(1'b1, rd);
    host.cond(1'b0);
    check(rd, {4'h0, n});
  endtask
  task automatic read_rec(input int k, input int slot);
    open_cmd(CMD_SELECTOR);
    host.send(8'(k), a1);
    check({7'h00, a1}, 8'h00);
    host.cond(1'b0);
    open_cmd(CMD_EVENT_READ);
    host.cond(1'b1);
    host.send({DEV_ADDR, 1'b1}, a1);
    host.recv(1'b0, rd);
    check(rd, {3'h0, REC_BYTES});
    for (int b = 0; b < 26; b++) begin
      host.recv(b == 25, rd);
      check(rd, rec[slot][8*b +: 8]);
    end
    host.cond(1'b0);
  endtask
  // Eight back-to-back captures, then one into a full store
  task automatic fill_all();
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < 26; b++) begin
        rec[i][8*b +: 8] = 8'(b * 7 + i * 29 + 1);
      end
      rec[i][157:96] = '0;
      rec[i][167:160] = {4'(i % 7), 4'((i + 3) % 7)};
      drive_rec(rec[i]);
      cap_valid <= 1'b1;
      @(posedge clock);
    end
    drive_rec(~rec[0]);
    @(posedge clock);
    cap_valid <= 1'b0;
    repeat (2) @(posedge clock);
    check({4'h0, stored_count}, 8'h08);
  endtask
  // Selection across slots, out-of-range index, repeated read
  task automatic select_and_read();
    read_rec(0, 0);
    read_rec(7, 7);
    read_rec(3, 3);
    read_rec(9, 3);
  endtask
  // Wrong address ignored, unknown command reads the fill byte
  task automatic other_cmds();
    host.cond(1'b1);
    host.send({DEV_ADDR ^ 7'h01, 1'b0}, a1);
    host.cond(1'b0);
    check({7'h00, a1}, 8'h01);
    open_cmd(8'h01);
    host.cond(1'b1);
    host.send({DEV_ADDR, 1'b1}, a1);
    host.recv(1'b1, rd);
    host.cond(1'b0);
    check(rd, FILL_BYTE);
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    cap_valid = 1'b0;
    drive_rec('0);
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    read_sel(4'h0);
    fill_all();
    read_sel(4'h8);
    select_and_read();
    other_cmds();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule
